// [design/gpc_params.svh]
// Register offsets, reset values and field positions of the GPIO port block.
`ifndef GPC_PARAMS_SVH
`define GPC_PARAMS_SVH
`define GPC_OFF_P0_DATA   8'h80
`define GPC_OFF_P1_DATA   8'h90
`define GPC_OFF_P1_DIR    8'h91
`define GPC_OFF_P1_PUP    8'h92
`define GPC_OFF_DRV_A     8'h96
`define GPC_OFF_DRV_B     8'h97
`define GPC_OFF_P0_DIR    8'h9A
`define GPC_OFF_P0_PUP    8'h9B
`define GPC_OFF_P2_DATA   8'hA0
`define GPC_OFF_P2_DIR    8'hA1
`define GPC_OFF_P2_PUP    8'hA2
`define GPC_OFF_P5_DATA   8'hD8
`define GPC_OFF_P5_DIR    8'hD9
`define GPC_OFF_P5_PUP    8'hDA
`define GPC_RST_BYTE      8'h00
`define GPC_PORT_PINS     8
`define GPC_P5_PINS       6
`define GPC_FULL_MASK     8'hFF
`define GPC_P5_RST        6'h00
`define GPC_P5_OE_IN      6'h3F
`define GPC_OE_IN_BYTE    8'hFF
`define GPC_DAT_IDLE      32'h0000_0000
`define GPC_DAT_PAD       24'h00_0000
`define GPC_P5_MASK       8'h3F
`define GPC_DIR_IN        1'b0
`define GPC_PUP_ON        1'b1
`define GPC_FLD_LO_L      1
`define GPC_FLD_LO_R      0
`define GPC_FLD_ML_L      3
`define GPC_FLD_ML_R      2
`define GPC_FLD_MH_L      5
`define GPC_FLD_MH_R      4
`define GPC_FLD_HI_L      7
`define GPC_FLD_HI_R      6
`endif

// [design/gpc_pkg.sv]
// Types shared by the GPIO port block.
package gpc_pkg;
  typedef enum logic [1:0] {
    GPC_DRV_LVL0 = 2'h0,
    GPC_DRV_LVL1 = 2'h1,
    GPC_DRV_LVL2 = 2'h2,
    GPC_DRV_LVL3 = 2'h3
  } gpc_drive_level_t;

  typedef enum logic [1:0] {
    GPC_BUS_IDLE = 2'b01,
    GPC_BUS_ACK  = 2'b10
  } gpc_bus_state_t;
endpackage : gpc_pkg

// [design/gpc_port_block.sv]
// GPIO port control block with a classic Wishbone register slave.
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "gpc_params.svh"

module gpc_port_block #(
  // Pin counts of the byte-wide ports and of port 5.
  parameter int PORT_PINS  = `GPC_PORT_PINS,
  parameter int PORT5_PINS = `GPC_P5_PINS
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Wishbone slave
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_we_i,
  input  wire logic [7:0] wb_adr_i,
  input  wire logic [3:0] wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]     wb_dat_o,
  output logic            wb_ack_o,
  output logic            wb_err_o,
  // Port 0 pins
  input  wire logic [7:0] port0_pin_i,
  output logic [7:0]      port0_pin_o,
  output logic [7:0]      port0_pin_oe_n_o,
  output logic [7:0]      port0_pullup_o,
  // Port 1 pins
  input  wire logic [7:0] port1_pin_i,
  output logic [7:0]      port1_pin_o,
  output logic [7:0]      port1_pin_oe_n_o,
  output logic [7:0]      port1_pullup_o,
  // Port 2 pins
  input  wire logic [7:0] port2_pin_i,
  output logic [7:0]      port2_pin_o,
  output logic [7:0]      port2_pin_oe_n_o,
  output logic [7:0]      port2_pullup_o,
  // Port 5 pins
  input  wire logic [5:0] port5_pin_i,
  output logic [5:0]      port5_pin_o,
  output logic [5:0]      port5_pin_oe_n_o,
  output logic [5:0]      port5_pullup_o,
  // Drive strength per pin group
  output logic [1:0]      port0_lower_drive_level_o,
  output logic [1:0]      port0_upper_drive_level_o,
  output logic [1:0]      port1_lower_drive_level_o,
  output logic [1:0]      port1_upper_drive_level_o,
  output logic [1:0]      port2_lower_drive_level_o,
  output logic [1:0]      port2_upper_drive_level_o,
  output logic [1:0]      port5_lower_drive_level_o,
  output logic [1:0]      port5_upper_pair_drive_level_o
);

  localparam int NPORT = 4;

  // The register map is byte wide with a six-pin port 5; other counts would misplace bits.
  if (PORT_PINS != `GPC_PORT_PINS) begin : g_bad_port_pins
    $error("PORT_PINS must equal the byte width of the port registers");
  end
  if (PORT5_PINS != `GPC_P5_PINS) begin : g_bad_port5_pins
    $error("PORT5_PINS must equal the six implemented port 5 bits");
  end

  // Ports are indexed 0,1,2,3 where index 3 is port 5.
  // Configuration state, one byte per port and register kind.
  logic [7:0] latch_q [NPORT];
  logic [7:0] dir_q   [NPORT];
  logic [7:0] pup_q   [NPORT];
  logic [7:0] drv_a_q;
  logic [7:0] drv_b_q;
  logic [7:0] sync1_q [NPORT];
  logic [7:0] sync2_q [NPORT];
  logic [7:0] pins_in [NPORT];
  logic [7:0] impl_mask [NPORT];

  gpc_pkg::gpc_bus_state_t bus_q;
  logic       req;
  logic       wr_en;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic       hit;

  // Port 5 is widened to a byte so every port shares one generate body.
  assign pins_in[0] = port0_pin_i;
  assign pins_in[1] = port1_pin_i;
  assign pins_in[2] = port2_pin_i;
  assign pins_in[3] = {2'h0, port5_pin_i};

  assign impl_mask[0] = `GPC_FULL_MASK;
  assign impl_mask[1] = `GPC_FULL_MASK;
  assign impl_mask[2] = `GPC_FULL_MASK;
  assign impl_mask[3] = `GPC_P5_MASK;

  // A new request is taken only from idle, so ack lasts exactly one cycle.
  assign req   = wb_cyc_i && wb_stb_i && (bus_q == gpc_pkg::GPC_BUS_IDLE);
  // Only byte lane zero carries register data; the upper lanes are ignored.
  assign wr_en = req && wb_we_i && wb_sel_i[0];
  assign wbyte = wb_dat_i[7:0];

  // The answer state lasts one cycle and returns to idle on its own.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_q <= gpc_pkg::GPC_BUS_IDLE;
    end else begin
      case (bus_q)
        gpc_pkg::GPC_BUS_IDLE: begin
          if (req) begin
            bus_q <= gpc_pkg::GPC_BUS_ACK;
          end
        end
        gpc_pkg::GPC_BUS_ACK: bus_q <= gpc_pkg::GPC_BUS_IDLE;
        default: bus_q <= gpc_pkg::GPC_BUS_IDLE;
      endcase
    end
  end

  genvar p;
  generate
    for (p = 0; p < NPORT; p++) begin : g_port
      // Each port decodes its own three addresses.
      logic [7:0] off_data;
      logic [7:0] off_dir;
      logic [7:0] off_pup;
      assign off_data = (p == 0) ? `GPC_OFF_P0_DATA : (p == 1) ? `GPC_OFF_P1_DATA :
                        (p == 2) ? `GPC_OFF_P2_DATA : `GPC_OFF_P5_DATA;
      assign off_dir  = (p == 0) ? `GPC_OFF_P0_DIR : (p == 1) ? `GPC_OFF_P1_DIR :
                        (p == 2) ? `GPC_OFF_P2_DIR : `GPC_OFF_P5_DIR;
      assign off_pup  = (p == 0) ? `GPC_OFF_P0_PUP : (p == 1) ? `GPC_OFF_P1_PUP :
                        (p == 2) ? `GPC_OFF_P2_PUP : `GPC_OFF_P5_PUP;

      // Pins are asynchronous to clk_i, so two flops precede any reader.
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sync1_q[p] <= `GPC_RST_BYTE;
        end else begin
          sync1_q[p] <= pins_in[p];
        end
      end

      // The second stage is the only reader of the first, which may be metastable.
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sync2_q[p] <= `GPC_RST_BYTE;
        end else begin
          sync2_q[p] <= sync1_q[p];
        end
      end

      // Port 5 upper bits are masked on write, so they read back as zero.
      // latch reset zero
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          latch_q[p] <= `GPC_RST_BYTE;
        end else if (wr_en && wb_adr_i == off_data) begin
          latch_q[p] <= wbyte & impl_mask[p];
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          dir_q[p] <= `GPC_RST_BYTE;
        end else if (wr_en && wb_adr_i == off_dir) begin
          dir_q[p] <= wbyte & impl_mask[p];
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          pup_q[p] <= `GPC_RST_BYTE;
        end else if (wr_en && wb_adr_i == off_pup) begin
          pup_q[p] <= wbyte & impl_mask[p];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drv_a_q <= `GPC_RST_BYTE;
    end else if (wr_en && wb_adr_i == `GPC_OFF_DRV_A) begin
      drv_a_q <= wbyte;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drv_b_q <= `GPC_RST_BYTE;
    end else if (wr_en && wb_adr_i == `GPC_OFF_DRV_B) begin
      // All eight bits are kept so software reads back what it wrote.
      drv_b_q <= wbyte;
    end
  end

  // Data addresses return synchronised pin levels, not the latch contents.
  // read pin levels
  always_comb begin
    rbyte = `GPC_RST_BYTE;
    hit   = 1'b1;
    case (wb_adr_i)
      `GPC_OFF_P0_DATA: rbyte = sync2_q[0];
      `GPC_OFF_P1_DATA: rbyte = sync2_q[1];
      `GPC_OFF_P2_DATA: rbyte = sync2_q[2];
      `GPC_OFF_P5_DATA: rbyte = sync2_q[3] & `GPC_P5_MASK;
      `GPC_OFF_P0_DIR:  rbyte = dir_q[0];
      `GPC_OFF_P1_DIR:  rbyte = dir_q[1];
      `GPC_OFF_P2_DIR:  rbyte = dir_q[2];
      `GPC_OFF_P5_DIR:  rbyte = dir_q[3];
      `GPC_OFF_P0_PUP:  rbyte = pup_q[0];
      `GPC_OFF_P1_PUP:  rbyte = pup_q[1];
      `GPC_OFF_P2_PUP:  rbyte = pup_q[2];
      `GPC_OFF_P5_PUP:  rbyte = pup_q[3];
      `GPC_OFF_DRV_A:   rbyte = drv_a_q;
      `GPC_OFF_DRV_B:   rbyte = drv_b_q;
      default:          hit   = 1'b0;
    endcase
  end

  // Unmapped addresses answer with err instead of ack.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req && hit;
    end
  end

  // An unmapped access gets err and changes no register, so a stray address is visible.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_err_o <= 1'b0;
    end else begin
      wb_err_o <= req && !hit;
    end
  end

  // Read data is zero outside an answer, so a stale byte is never mistaken for a reply.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= `GPC_DAT_IDLE;
    end else begin
      wb_dat_o <= req ? {`GPC_DAT_PAD, rbyte} : `GPC_DAT_IDLE;
    end
  end

  // Pin drivers are registered so every output comes from a flop.
  // outputs drive latch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port0_pin_o <= `GPC_RST_BYTE;
      port1_pin_o <= `GPC_RST_BYTE;
      port2_pin_o <= `GPC_RST_BYTE;
      port5_pin_o <= `GPC_P5_RST;
    end else begin
      port0_pin_o <= latch_q[0];
      port1_pin_o <= latch_q[1];
      port2_pin_o <= latch_q[2];
      port5_pin_o <= latch_q[3][5:0];
    end
  end

  // Enables are active low, so a reset port floats as an input.
  // direction to enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port0_pin_oe_n_o <= `GPC_OE_IN_BYTE;
      port1_pin_oe_n_o <= `GPC_OE_IN_BYTE;
      port2_pin_oe_n_o <= `GPC_OE_IN_BYTE;
      port5_pin_oe_n_o <= `GPC_P5_OE_IN;
    end else begin
      port0_pin_oe_n_o <= ~dir_q[0];
      port1_pin_oe_n_o <= ~dir_q[1];
      port2_pin_oe_n_o <= ~dir_q[2];
      port5_pin_oe_n_o <= ~dir_q[3][5:0];
    end
  end

  // A driven pin never has its pull-up on, which would waste current.
  // pull-up gated per pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port0_pullup_o <= `GPC_RST_BYTE;
      port1_pullup_o <= `GPC_RST_BYTE;
      port2_pullup_o <= `GPC_RST_BYTE;
      port5_pullup_o <= `GPC_P5_RST;
    end else begin
      port0_pullup_o <= pup_q[0] & ~dir_q[0];
      port1_pullup_o <= pup_q[1] & ~dir_q[1];
      port2_pullup_o <= pup_q[2] & ~dir_q[2];
      port5_pullup_o <= pup_q[3][5:0] & ~dir_q[3][5:0];
    end
  end

  // Level 0 is the strongest drive, so reset leaves full drive capability.
  // drive fields A
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port0_lower_drive_level_o      <= gpc_pkg::GPC_DRV_LVL0;
      port0_upper_drive_level_o      <= gpc_pkg::GPC_DRV_LVL0;
      port1_lower_drive_level_o      <= gpc_pkg::GPC_DRV_LVL0;
      port1_upper_drive_level_o      <= gpc_pkg::GPC_DRV_LVL0;
    end else begin
      port0_lower_drive_level_o      <= drv_a_q[`GPC_FLD_LO_L:`GPC_FLD_LO_R];
      port0_upper_drive_level_o      <= drv_a_q[`GPC_FLD_ML_L:`GPC_FLD_ML_R];
      port1_lower_drive_level_o      <= drv_a_q[`GPC_FLD_MH_L:`GPC_FLD_MH_R];
      port1_upper_drive_level_o      <= drv_a_q[`GPC_FLD_HI_L:`GPC_FLD_HI_R];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port2_lower_drive_level_o      <= gpc_pkg::GPC_DRV_LVL0;
      port2_upper_drive_level_o      <= gpc_pkg::GPC_DRV_LVL0;
      port5_lower_drive_level_o      <= gpc_pkg::GPC_DRV_LVL0;
      port5_upper_pair_drive_level_o <= gpc_pkg::GPC_DRV_LVL0;
    end else begin
      port2_lower_drive_level_o      <= drv_b_q[`GPC_FLD_LO_L:`GPC_FLD_LO_R];
      port2_upper_drive_level_o      <= drv_b_q[`GPC_FLD_ML_L:`GPC_FLD_ML_R];
      port5_lower_drive_level_o      <= drv_b_q[`GPC_FLD_MH_L:`GPC_FLD_MH_R];
      port5_upper_pair_drive_level_o <= drv_b_q[`GPC_FLD_HI_L:`GPC_FLD_HI_R];
    end
  end

endmodule : gpc_port_block
`default_nettype wire

// [dv/gpc_port_block_chk.sv]
// Checker of bus answers and pin configuration outputs.
`timescale 1ns/1ps
`default_nettype none
module gpc_port_block_chk (
  // Clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  // Pin controls
  input wire logic [7:0]  port0_pullup_o,
  input wire logic [7:0]  port0_pin_oe_n_o,
  input wire logic [1:0]  port0_lower_drive_level_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // The slave takes nothing while it answers; requests in the cycle after an answer are skipped here too.
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && !$past(wb_ack_o) && !$past(wb_err_o);
  endsequence
  sequence s_wr(a);
    s_take ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == a);
  endsequence
  a_answer_once: assert property (s_take |=> (wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o))
    else $error("bus answer not a single pulse");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_err_unmapped: assert property (s_take ##0 (wb_adr_i == 8'h95) |=> wb_err_o)
    else $error("unmapped access not refused");
  a_pullup_gate: assert property ((port0_pullup_o & ~port0_pin_oe_n_o) == 8'h0)
    else $error("pull-up on a driven pin");
  a_reset_input: assert property ($past(rst_i) |-> port0_pin_oe_n_o == 8'hFF && port0_pullup_o == 8'h0)
    else $error("pins not inputs after reset");
  a_dir_follow: assert property (s_wr(8'h9A) |=> ##1 port0_pin_oe_n_o == ~$past(wb_dat_i[7:0], 2))
    else $error("direction not applied");
  a_drive_follow: assert property (s_wr(8'h96) |=> ##1 port0_lower_drive_level_o == $past(wb_dat_i[1:0], 2))
    else $error("drive level not applied");
endmodule : gpc_port_block_chk
`default_nettype wire

// [dv/gpc_pin_load.sv]
// Load model of one port's pins: outside driver, pull-up and floating level.
`timescale 1ns/1ps
`default_nettype none
module gpc_pin_load #(
  parameter int W = 8
) (
  // Block side
  input  wire logic [W-1:0] drv_i,
  input  wire logic [W-1:0] oe_n_i,
  input  wire logic [W-1:0] pu_i,
  // Outside source
  input  wire logic [W-1:0] ext_i,
  input  wire logic [W-1:0] ext_en_i,
  output logic      [W-1:0] level_o
);
  // pin level resolve.
  // A floating pin shows the inverse of the outside value, so a stale level never passes.
  always_comb begin
    for (int i = 0; i < W; i++) begin
      level_o[i] = !oe_n_i[i] ? drv_i[i] : ext_en_i[i] ? ext_i[i] : pu_i[i] ? 1'b1 : ~ext_i[i];
    end
  end
endmodule : gpc_pin_load
`default_nettype wire

// [dv/tb_gpc_port_block.sv]
// Testbench of the GPIO port block.
`timescale 1ns/1ps
`default_nettype none
module tb_gpc_port_block;
  logic clk_i = 1'b0, rst_i, cyc, stb, we, ack, err;
  logic [7:0] adr, ext, en, o0, o1, o2, e0, e1, e2, u0, u1, u2, l0, l1, l2;
  logic [5:0] o5, e5, u5, l5;
  logic [3:0] sel;
  logic [31:0] dat, rdat, q;
  logic [1:0] d [8];
  logic [7:0] all [14] = '{8'h80, 8'h90, 8'hA0, 8'hD8, 8'h91, 8'h92, 8'h96, 8'h97, 8'h9A,
                           8'h9B, 8'hA1, 8'hA2, 8'hD9, 8'hDA};
  int fails = 0, checks = 0;
  always #25 clk_i = ~clk_i;
  gpc_pin_load #(.W(8)) m0 (.drv_i(o0), .oe_n_i(e0), .pu_i(u0), .ext_i(ext), .ext_en_i(en), .level_o(l0));
  gpc_pin_load #(.W(8)) m1 (.drv_i(o1), .oe_n_i(e1), .pu_i(u1), .ext_i(ext), .ext_en_i(en), .level_o(l1));
  gpc_pin_load #(.W(8)) m2 (.drv_i(o2), .oe_n_i(e2), .pu_i(u2), .ext_i(ext), .ext_en_i(en), .level_o(l2));
  gpc_pin_load #(.W(6)) m5 (.drv_i(o5), .oe_n_i(e5), .pu_i(u5), .ext_i(ext[5:0]),
                            .ext_en_i(en[5:0]), .level_o(l5));
  gpc_port_block dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
    .port0_pin_i(l0), .port0_pin_o(o0), .port0_pin_oe_n_o(e0), .port0_pullup_o(u0),
    .port1_pin_i(l1), .port1_pin_o(o1), .port1_pin_oe_n_o(e1), .port1_pullup_o(u1),
    .port2_pin_i(l2), .port2_pin_o(o2), .port2_pin_oe_n_o(e2), .port2_pullup_o(u2),
    .port5_pin_i(l5), .port5_pin_o(o5), .port5_pin_oe_n_o(e5), .port5_pullup_o(u5),
    .port0_lower_drive_level_o(d[0]), .port0_upper_drive_level_o(d[1]),
    .port1_lower_drive_level_o(d[2]), .port1_upper_drive_level_o(d[3]),
    .port2_lower_drive_level_o(d[4]), .port2_upper_drive_level_o(d[5]),
    .port5_lower_drive_level_o(d[6]), .port5_upper_pair_drive_level_o(d[7]));
  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  // One classic cycle; the request stands until the answer edge.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] v, input logic [3:0] s,
                      output logic e);
    int n;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, 24'h0, v, s};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
    q = rdat;
    e = err;
    {cyc, stb} <= 2'b00;
    if (ack !== 1'b1 && err !== 1'b1) begin
      fails++;
      conclude();
    end
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic e;
    xfer(1'b1, a, v, 4'h1, e);
    repeat (3) @(negedge clk_i);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic e;
    xfer(1'b0, a, 8'h00, 4'h1, e);
  endtask : rd
  initial begin
    logic e;
    {rst_i, cyc, stb, we, adr, dat, sel, ext, en} = {4'b1000, 8'h00, 32'h0, 4'h0, 8'h00, 8'hFF};
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (all[i]) begin
      rd(all[i]);
      chk("reset", q, 32'h0);
    end
    chk("oe1", e1, 8'hFF);
    chk("pu1", u1, 8'h00);
    for (int i = 4; i < 14; i++) begin
      wr(all[i], 8'hE4);
      rd(all[i]);
      chk("cfg", q, all[i] > 8'hD0 ? 8'h24 : 8'hE4);
    end
    foreach (d[i]) chk("drv", d[i], i % 4);
    chk("oe1", e1, 8'h1B);
    chk("oe0", e0, 8'h1B);
    chk("oe2", e2, 8'h1B);
    chk("oe5", e5, 6'h1B);
    chk("pu1", u1, 8'h00);
    chk("pu0", u0, 8'h00);
    chk("pu5", u5, 6'h00);
    wr(8'h92, 8'h1B);
    chk("pu1", u1, 8'h1B);
    wr(8'h90, 8'hFF);
    wr(8'hD8, 8'hFF);
    chk("p1o", o1, 8'hFF);
    chk("p5o", o5, 6'h3F);
    chk("p0o", o0, 8'h00);
    chk("p2o", o2, 8'h00);
    chk("pu2", u2, 8'h00);
    rd(8'h90);
    chk("p1lvl", q, 8'hE4);
    rd(8'hD8);
    chk("p5lvl", q, 8'h24);
    ext <= 8'h1B;
    repeat (3) @(negedge clk_i);
    rd(8'h90);
    chk("p1in", q, 8'hFF);
    en <= 8'h00;
    repeat (3) @(negedge clk_i);
    rd(8'h90);
    chk("p1pu", q, 8'hFF);
    rd(8'h80);
    chk("p0float", q, 8'h00);
    xfer(1'b1, 8'h95, 8'hFF, 4'h1, e);
    chk("err", e, 1'b1);
    xfer(1'b1, 8'h91, 8'h00, 4'h0, e);
    rd(8'h91);
    chk("nosel", q, 8'hE4);
    conclude();
  end
endmodule : tb_gpc_port_block
bind gpc_port_block gpc_port_block_chk chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .port0_pullup_o(port0_pullup_o), .port0_pin_oe_n_o(port0_pin_oe_n_o),
  .port0_lower_drive_level_o(port0_lower_drive_level_o));
`default_nettype wire
